// >>> design/asd_pkg.sv
// package of constants for the analog scan and output buffer controller
package asd_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] OFS_BCR = 8'h04;
	localparam logic [7:0] OFS_SCAN = 8'h08;
	localparam logic [7:0] OFS_OUT_PORT = 8'h18;
	localparam logic [7:0] OFS_OUT_CTRL = 8'h1c;
	localparam logic [31:0] RST_BCR = 32'h0000_0010;
	localparam logic [14:0] RST_THRESH = 15'h7ffe;
	localparam logic [31:0] RST_SCAN = 32'h0000_0000;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int BCR_FUNC_LO = 0;
	localparam int BCR_OFFSET_BIN = 4;
	localparam int BCR_IN_SYNC = 5;
	localparam int BCR_THR_EDGE = 6;
	localparam int SCN_SIZE_LO = 0;
	localparam int SCN_SINGLE = 2;
	localparam int SCN_CHAN_LO = 4;
	localparam int SCN_SRC_LO = 8;
	localparam int OC_CLEAR = 15;
	localparam int OC_FLAG = 16;
	localparam int OW_TAG_LO = 16;
	localparam int OW_GROUP = 19;
	localparam int OW_BURST = 20;

	// ************************************************************
	// encodings
	// ************************************************************
	typedef enum logic [3:0] {
		FN_DIFF = 4'h0,
		FN_SINGLE = 4'h1,
		FN_ZERO = 4'h2,
		FN_VREF = 4'h3,
		FN_MON0 = 4'h4,
		FN_MON7 = 4'hb
	} asd_func_e;
	typedef enum logic [1:0] {
		SZ_2 = 2'h0,
		SZ_4 = 2'h1,
		SZ_8 = 2'h2,
		SZ_16 = 2'h3
	} asd_size_e;
	typedef enum logic [1:0] {
		SRC_GEN_A = 2'h0,
		SRC_GEN_B = 2'h1,
		SRC_EXT = 2'h2,
		SRC_SOFT = 2'h3
	} asd_src_e;
	typedef enum logic [2:0] {
		IR_ZERO = 3'h0,
		IR_VREF = 3'h1,
		IR_MON = 3'h2,
		IR_SINGLE = 3'h3,
		IR_DIFF = 3'h4
	} asd_route_e;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_HZ = 40_000_000;
	localparam int CONV_PER_S = 300_000;
	// slightly above 300k: round the cycle count down
	localparam int CONV_CYC = CLK_HZ / CONV_PER_S;
	localparam int OUT_DEPTH = 32768;
	localparam int XFER_DEPTH = 256;
	localparam logic [15:0] MIDSCALE = 16'h8000;
endpackage

// >>> design/asd_fifo.sv
// parameterised synchronous fifo with valid/ready on both sides
module asd_fifo #(
	parameter int WIDTH = 21,
	parameter int DEPTH = 256,
	parameter int AW = $clog2(DEPTH)
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	// fill level
	output logic [AW:0] count
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q, rd_q;
	logic [AW:0] cnt_q;
	logic push, pop;

	assign in_ready = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != '0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem[rd_q];
	assign count = cnt_q;

	always_ff @(posedge clk) begin
		if (push)
			mem[wr_q] <= in_data;
	end

	always_ff @(posedge clk) begin
		if (rst || flush) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

// >>> design/asd_top.sv
// analog input scan sequencer and analog output buffer control
// Function
// - four-bit input function field selects diff, single, zero, vref, monitor
// - after reset inputs are differential; channels even-numbered 00 to 14
// - single-ended: sixteen channels 00 to 15 against common return
// - selftests disconnect external lines; ground, reference or output routed
// - zero test expects midscale, reference test expects 96.15 percent
// - each scan clock converts selected channels once, from channel 00 up
// - conversions run at fixed rate slightly above 300k per second
// - scan clocks arriving during a scan are ignored
// - scan clock source: rate generator a or b, external sync, software
// - software scan bit starts one scan, reads high, clears when done
// - falling edge of external sync starts one scan
// - scan mode low: scan size gives 2, 4, 8 or 16 channels from 00
// - two-channel size overrides input mode, converts channels 00 and 01
// - scan mode high: only the single selected channel is converted
// - output buffer is write-only port of 32K, drains via 256 fifo
// - output word: data 0-15, channel 16-18, group end 19, burst end 20
// - reading output port returns zero and leaves buffer untouched
// - offset binary by default; two's complement when coding bit cleared
// - output clear bit empties buffer then self-clears
// - threshold flag high while stored count exceeds threshold; resets 7ffe
// - threshold interrupt on rising or falling edge, chosen by config
// - stored input sample carries channel 00 marker in bit 16
module asd_top (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic SRST,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_WDATA,
	output logic [31:0] REG_RDATA,
	output logic REG_WR_READY,
	// scan clock sources
	input wire logic GEN_A_TICK,
	input wire logic GEN_B_TICK,
	input wire logic EXT_SYNC,
	// converter side
	output logic ADC_START,
	output logic [3:0] ADC_CHAN,
	output logic [2:0] INPUT_ROUTE,
	output logic [2:0] MON_CHAN,
	input wire logic ADC_DONE,
	input wire logic [15:0] ADC_DATA,
	output logic SAMPLE_VALID,
	output logic [16:0] SAMPLE_DATA,
	output logic SCAN_BUSY,
	// output data path
	output logic DAC_VALID,
	input wire logic DAC_READY,
	output logic [15:0] DAC_DATA,
	output logic [2:0] DAC_CHAN,
	output logic DAC_GROUP_END,
	output logic DAC_BURST_END,
	output logic THRESH_FLAG,
	output logic THRESH_EVENT
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_CONV = 2'h1,
		ST_WAIT = 2'h2
	} asd_state_e;

	// ************************************************************
	// registers
	// ************************************************************
	logic [31:0] bcr_q;
	logic [31:0] scan_q;
	logic [14:0] thresh_q;
	logic clear_q;
	logic wr_bcr, wr_scan, wr_ctrl, wr_port;
	logic scan_done;

	assign wr_bcr = REG_WR && REG_ADDR == asd_pkg::OFS_BCR;
	assign wr_scan = REG_WR && REG_ADDR == asd_pkg::OFS_SCAN;
	assign wr_ctrl = REG_WR && REG_ADDR == asd_pkg::OFS_OUT_CTRL;
	assign wr_port = REG_WR && REG_ADDR == asd_pkg::OFS_OUT_PORT;

	// software scan bit: set by write, cleared at the end of any scan
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			bcr_q <= asd_pkg::RST_BCR;
		end else begin
			if (wr_bcr) begin
				bcr_q <= REG_WDATA;
				bcr_q[asd_pkg::BCR_IN_SYNC] <=
					REG_WDATA[asd_pkg::BCR_IN_SYNC] |
					bcr_q[asd_pkg::BCR_IN_SYNC];
			end
			if (scan_done && !(wr_bcr && REG_WDATA[asd_pkg::BCR_IN_SYNC]))
				bcr_q[asd_pkg::BCR_IN_SYNC] <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST)
			scan_q <= asd_pkg::RST_SCAN;
		else if (wr_scan)
			scan_q <= REG_WDATA;
	end

	always_ff @(posedge SYS_CLK) begin
		if (SRST)
			thresh_q <= asd_pkg::RST_THRESH;
		else if (wr_ctrl)
			thresh_q <= REG_WDATA[14:0];
	end

	// clear holds one cycle while both fifos flush
	always_ff @(posedge SYS_CLK) begin
		if (SRST)
			clear_q <= 1'b0;
		else if (wr_ctrl && REG_WDATA[asd_pkg::OC_CLEAR])
			clear_q <= 1'b1;
		else
			clear_q <= 1'b0;
	end

	// ************************************************************
	// input routing
	// ************************************************************
	logic [3:0] func;
	assign func = bcr_q[asd_pkg::BCR_FUNC_LO +: 4];

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			INPUT_ROUTE <= asd_pkg::IR_DIFF;
			MON_CHAN <= 3'h0;
		end else begin
			case (func)
			asd_pkg::FN_DIFF: INPUT_ROUTE <= asd_pkg::IR_DIFF;
			asd_pkg::FN_SINGLE: INPUT_ROUTE <= asd_pkg::IR_SINGLE;
			asd_pkg::FN_ZERO: INPUT_ROUTE <= asd_pkg::IR_ZERO;
			asd_pkg::FN_VREF: INPUT_ROUTE <= asd_pkg::IR_VREF;
			default: begin
				if (func >= asd_pkg::FN_MON0 && func <= asd_pkg::FN_MON7) begin
					INPUT_ROUTE <= asd_pkg::IR_MON;
					MON_CHAN <= 3'(func - asd_pkg::FN_MON0);
				end else begin
					INPUT_ROUTE <= asd_pkg::IR_DIFF;
				end
			end
			endcase
		end
	end

	// ************************************************************
	// scan trigger
	// ************************************************************
	logic ext_q;
	logic trig;
	logic [1:0] src;
	logic soft_start_q;
	asd_state_e st_q;

	assign src = scan_q[asd_pkg::SCN_SRC_LO +: 2];

	always_ff @(posedge SYS_CLK) begin
		if (SRST)
			ext_q <= 1'b1;
		else
			ext_q <= EXT_SYNC;
	end

	// software start pulses once per rising of the bit
	always_ff @(posedge SYS_CLK) begin
		if (SRST)
			soft_start_q <= 1'b0;
		else
			soft_start_q <= wr_bcr && REG_WDATA[asd_pkg::BCR_IN_SYNC] &&
				!bcr_q[asd_pkg::BCR_IN_SYNC];
	end

	always_comb begin
		case (src)
		asd_pkg::SRC_GEN_A: trig = GEN_A_TICK;
		asd_pkg::SRC_GEN_B: trig = GEN_B_TICK;
		asd_pkg::SRC_EXT: trig = ext_q && !EXT_SYNC;
		asd_pkg::SRC_SOFT: trig = soft_start_q;
		default: trig = 1'b0;
		endcase
	end

	// ************************************************************
	// scan sequencer
	// ************************************************************
	function automatic logic [4:0] scan_len(input logic [1:0] sz);
		case (sz)
		asd_pkg::SZ_2: scan_len = 5'd2;
		asd_pkg::SZ_4: scan_len = 5'd4;
		asd_pkg::SZ_8: scan_len = 5'd8;
		default: scan_len = 5'd16;
		endcase
	endfunction

	logic [4:0] len_q, idx_q;
	logic [7:0] rate_q;
	logic single_q, two_q, diff_q;
	logic [3:0] sel_q;

	assign scan_done = (st_q == ST_WAIT) && ADC_DONE &&
		(idx_q + 5'd1 == len_q);
	assign SCAN_BUSY = (st_q != ST_IDLE);

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			st_q <= ST_IDLE;
			idx_q <= 5'd0;
			len_q <= 5'd1;
			single_q <= 1'b0;
			two_q <= 1'b0;
			diff_q <= 1'b1;
			sel_q <= 4'h0;
			rate_q <= 8'h00;
		end else begin
			case (st_q)
			ST_IDLE: begin
				// triggers while busy never reach this state
				if (trig) begin
					single_q <= scan_q[asd_pkg::SCN_SINGLE];
					sel_q <= scan_q[asd_pkg::SCN_CHAN_LO +: 4];
					two_q <= !scan_q[asd_pkg::SCN_SINGLE] &&
						scan_q[1:0] == asd_pkg::SZ_2;
					// decoded from the function field, not the lagging route
					diff_q <= func == asd_pkg::FN_DIFF ||
						func > asd_pkg::FN_MON7;
					len_q <= scan_q[asd_pkg::SCN_SINGLE] ? 5'd1 :
						scan_len(scan_q[1:0]);
					idx_q <= 5'd0;
					rate_q <= 8'h00;
					st_q <= ST_CONV;
				end
			end
			ST_CONV: begin
				// fixed conversion pacing regardless of scan clock
				rate_q <= rate_q + 8'h01;
				st_q <= ST_WAIT;
			end
			ST_WAIT: begin
				if (rate_q != 8'(asd_pkg::CONV_CYC - 1))
					rate_q <= rate_q + 8'h01;
				if (ADC_DONE) begin
					if (idx_q + 5'd1 == len_q) begin
						st_q <= ST_IDLE;
					end else begin
						idx_q <= idx_q + 5'd1;
					end
				end
				if (!ADC_DONE || idx_q + 5'd1 != len_q) begin
					if (rate_q == 8'(asd_pkg::CONV_CYC - 1) &&
						!(ADC_DONE && idx_q + 5'd1 == len_q)) begin
						rate_q <= 8'h00;
						st_q <= ST_CONV;
					end
				end
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end

	// channel number seen by the converter
	always_comb begin
		if (single_q)
			ADC_CHAN = sel_q;
		else if (two_q)
			ADC_CHAN = idx_q[3:0];
		else if (diff_q)
			ADC_CHAN = {idx_q[2:0], 1'b0};
		else
			ADC_CHAN = idx_q[3:0];
	end
	assign ADC_START = (st_q == ST_CONV);

	// stored sample with coding conversion and channel 00 marker
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			SAMPLE_VALID <= 1'b0;
			SAMPLE_DATA <= 17'h00000;
		end else begin
			SAMPLE_VALID <= (st_q == ST_WAIT) && ADC_DONE;
			SAMPLE_DATA[16] <= (ADC_CHAN == 4'h0);
			SAMPLE_DATA[15:0] <= bcr_q[asd_pkg::BCR_OFFSET_BIN] ?
				ADC_DATA : ADC_DATA ^ asd_pkg::MIDSCALE;
		end
	end

	// ************************************************************
	// output buffer and transfer fifo
	// ************************************************************
	logic ob_valid, ob_ready, xf_valid;
	logic [20:0] ob_data, xf_data;
	logic [15:0] ob_count;
	logic thr_q;

	// upper bits of the written word are dropped here
	asd_fifo #(.WIDTH(21), .DEPTH(asd_pkg::OUT_DEPTH)) u_outbuf (
		.clk(SYS_CLK),
		.rst(SRST),
		.flush(clear_q),
		.in_valid(wr_port),
		.in_ready(REG_WR_READY),
		.in_data(REG_WDATA[20:0]),
		.out_valid(ob_valid),
		.out_ready(ob_ready),
		.out_data(ob_data),
		.count(ob_count)
	);

	asd_fifo #(.WIDTH(21), .DEPTH(asd_pkg::XFER_DEPTH)) u_xfer (
		.clk(SYS_CLK),
		.rst(SRST),
		.flush(clear_q),
		.in_valid(ob_valid),
		.in_ready(ob_ready),
		.in_data(ob_data),
		.out_valid(xf_valid),
		.out_ready(DAC_READY),
		.out_data(xf_data),
		.count()
	);

	assign DAC_VALID = xf_valid;
	assign DAC_DATA = bcr_q[asd_pkg::BCR_OFFSET_BIN] ?
		xf_data[15:0] : xf_data[15:0] ^ asd_pkg::MIDSCALE;
	assign DAC_CHAN = xf_data[asd_pkg::OW_TAG_LO +: 3];
	assign DAC_GROUP_END = xf_data[asd_pkg::OW_GROUP];
	assign DAC_BURST_END = xf_data[asd_pkg::OW_BURST];

	// ************************************************************
	// threshold flag and edge event
	// ************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (SRST)
			thr_q <= 1'b0;
		else
			thr_q <= ob_count > {1'b0, thresh_q};
	end
	assign THRESH_FLAG = thr_q;

	logic thr_d1_q;
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			thr_d1_q <= 1'b0;
			THRESH_EVENT <= 1'b0;
		end else begin
			thr_d1_q <= thr_q;
			THRESH_EVENT <= bcr_q[asd_pkg::BCR_THR_EDGE] ?
				(thr_d1_q && !thr_q) : (!thr_d1_q && thr_q);
		end
	end

	// ************************************************************
	// register read
	// ************************************************************
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			REG_RDATA <= 32'h0000_0000;
		end else if (REG_RD) begin
			case (REG_ADDR)
			asd_pkg::OFS_BCR: REG_RDATA <= bcr_q;
			asd_pkg::OFS_SCAN: REG_RDATA <= scan_q;
			asd_pkg::OFS_OUT_CTRL:
				REG_RDATA <= {15'h0000, thr_q, clear_q, thresh_q};
			asd_pkg::OFS_OUT_PORT: REG_RDATA <= 32'h0000_0000;
			default: REG_RDATA <= 32'h0000_0000;
			endcase
		end
	end
endmodule

// >>> tb/asd_chk_properties.sv
// port assertions for the scan sequencer and output buffer control
module asd_chk (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic SRST,
	// register port
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_WDATA,
	input wire logic [31:0] REG_RDATA,
	input wire logic REG_WR_READY,
	// converter side
	input wire logic ADC_START,
	input wire logic [3:0] ADC_CHAN,
	input wire logic ADC_DONE,
	input wire logic [2:0] INPUT_ROUTE,
	input wire logic SAMPLE_VALID,
	input wire logic [16:0] SAMPLE_DATA,
	input wire logic SCAN_BUSY,
	// output path
	input wire logic DAC_VALID,
	input wire logic DAC_READY,
	input wire logic [15:0] DAC_DATA,
	input wire logic [2:0] DAC_CHAN,
	input wire logic THRESH_FLAG
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************
	// helpers
	// ****************************************
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (SRST);
	logic clr;
	logic [7:0] gap_q;
	assign clr = REG_WR && REG_ADDR == asd_pkg::OFS_OUT_CTRL
		&& REG_WDATA[asd_pkg::OC_CLEAR];
	// cycles since the last conversion start
	always_ff @(posedge SYS_CLK) begin
		if (SRST || ADC_START)
			gap_q <= 8'h01;
		else if (gap_q != 8'hff)
			gap_q <= gap_q + 8'h01;
	end
	AST_RESET_STATE: assert property (
		$fell(SRST) |-> INPUT_ROUTE == 3'h4 && REG_WR_READY && !SCAN_BUSY
		&& !DAC_VALID && !THRESH_FLAG && REG_RDATA == 32'h0)
		else $error("state after reset wrong");
	AST_START_IN_SCAN: assert property (
		ADC_START |-> SCAN_BUSY) else $error("start outside scan");
	AST_SAMPLE_AFTER_DONE: assert property (
		ADC_DONE && SCAN_BUSY |=> SAMPLE_VALID)
		else $error("no sample after done");
	AST_CHAN0_MARKER: assert property (
		SAMPLE_VALID |-> SAMPLE_DATA[16] == ($past(ADC_CHAN) == 4'h0))
		else $error("channel marker wrong");
	AST_CONV_PACING: assert property (
		ADC_START && $past(SCAN_BUSY) |-> gap_q >= 8'h85)
		else $error("conversions too close");
	AST_CHAN_HOLD: assert property (
		ADC_START |=> $stable(ADC_CHAN) [*4])
		else $error("channel moved in conversion");
	AST_DAC_HOLD: assert property (
		DAC_VALID && !DAC_READY && !clr && !$past(clr) && !$past(clr, 2)
		|=> DAC_VALID && $stable(DAC_DATA) && $stable(DAC_CHAN))
		else $error("head word not held");
	AST_PORT_READ_ZERO: assert property (
		REG_RD && REG_ADDR == asd_pkg::OFS_OUT_PORT |=> REG_RDATA == 32'h0)
		else $error("port read not zero");
	cover property (SAMPLE_VALID && SAMPLE_DATA[16]);
	cover property ($rose(THRESH_FLAG));
	cover property (DAC_VALID && DAC_READY);
endmodule

bind asd_top asd_chk u_chk (.SYS_CLK(SYS_CLK), .SRST(SRST),
	.REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
	.REG_WR_READY(REG_WR_READY), .ADC_START(ADC_START),
	.ADC_CHAN(ADC_CHAN), .ADC_DONE(ADC_DONE), .INPUT_ROUTE(INPUT_ROUTE),
	.SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_DATA(SAMPLE_DATA),
	.SCAN_BUSY(SCAN_BUSY), .DAC_VALID(DAC_VALID), .DAC_READY(DAC_READY),
	.DAC_DATA(DAC_DATA), .DAC_CHAN(DAC_CHAN), .THRESH_FLAG(THRESH_FLAG));

// >>> tb/asd_adc_model.sv
// converter model answering each start after a prompt or slow delay
module asd_adc_model (
	// clock and pacing
	input wire logic clk,
	input wire logic slow,
	// converter handshake
	input wire logic start,
	input wire logic [3:0] chan,
	output logic done,
	output logic [15:0] data
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt = 0;
	logic [3:0] ch_q = 4'h0;
	initial begin
		done = 1'b0;
		data = 16'h0;
	end
	// data toggles outside the done cycle so stale values never match
	always @(posedge clk) begin
		done <= 1'b0;
		data <= ~data;
		if (start) begin
			ch_q <= chan;
			cnt <= slow ? 40 : 6;
		end else if (cnt == 1) begin
			done <= 1'b1;
			data <= {12'h5a0, ch_q};
		end
		if (cnt != 0 && !start)
			cnt <= cnt - 1;
	end
endmodule

// >>> tb/tb.sv
// self-checking bench for the scan and output buffer controller
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
	failures++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk, srst, reg_wr, reg_rd, gen_a, gen_b, ext_sync;
	logic dac_ready, slow, wr_ready, adc_start, adc_done, smp_valid, busy;
	logic dac_valid, grp_end, brst_end, thr_flag, thr_event;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [3:0] adc_chan;
	logic [2:0] route, mon_chan, dac_chan;
	logic [15:0] adc_data, dac_data;
	logic [16:0] smp_data;
	logic [3:0] chq[$];
	logic [16:0] smq[$];
	int failures = 0;
	int n_compared = 0;
	int n_ev = 0;
	int cyc = 0;
	asd_top DUT (.SYS_CLK(sys_clk), .SRST(srst), .REG_ADDR(reg_addr),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata),
		.REG_RDATA(reg_rdata), .REG_WR_READY(wr_ready), .GEN_A_TICK(gen_a),
		.GEN_B_TICK(gen_b), .EXT_SYNC(ext_sync), .ADC_START(adc_start),
		.ADC_CHAN(adc_chan), .INPUT_ROUTE(route), .MON_CHAN(mon_chan),
		.ADC_DONE(adc_done), .ADC_DATA(adc_data), .SAMPLE_VALID(smp_valid),
		.SAMPLE_DATA(smp_data), .SCAN_BUSY(busy), .DAC_VALID(dac_valid),
		.DAC_READY(dac_ready), .DAC_DATA(dac_data), .DAC_CHAN(dac_chan),
		.DAC_GROUP_END(grp_end), .DAC_BURST_END(brst_end),
		.THRESH_FLAG(thr_flag), .THRESH_EVENT(thr_event));
	asd_adc_model u_adc (.clk(sys_clk), .slow(slow), .start(adc_start),
		.chan(adc_chan), .done(adc_done), .data(adc_data));
	always #12.5 sys_clk = ~sys_clk;
	// ****************************************
	// monitor and timeout
	// ****************************************
	always @(posedge sys_clk) begin
		if (adc_start)
			chq.push_back(adc_chan);
		if (smp_valid)
			smq.push_back(smp_data);
		if (thr_event)
			n_ev++;
		cyc++;
		if (cyc == 90000) begin
			failures++;
			results();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// waits out one scan, then compares channels and samples
	task automatic run(input logic [3:0] ex[$], input logic ofs);
		int k;
		k = 0;
		while (busy !== 1'b1 && k < 20) begin
			@(posedge sys_clk);
			k++;
		end
		while (busy !== 1'b0 && k < 4000) begin
			@(posedge sys_clk);
			k++;
		end
		tick(300);
		`CHK("scan length", ex.size(), chq.size())
		`CHK("sample count", ex.size(), smq.size())
		foreach (ex[i]) begin
			`CHK("channel", ex[i], chq[i])
			`CHK("sample", {ex[i] == 4'h0, {12'h5a0, ex[i]} ^ {~ofs, 15'h0}},
				smq[i])
		end
		chq = {};
		smq = {};
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		logic [31:0] d;
		rd(asd_pkg::OFS_OUT_CTRL, d);
		`CHK("ctrl reset", 32'h0000_7ffe, d)
		rd(asd_pkg::OFS_OUT_PORT, d);
		`CHK("port read", 32'h0, d)
		rd(8'h3c, d);
		`CHK("unmapped read", 32'h0, d)
		rd(asd_pkg::OFS_BCR, d);
		`CHK("bcr reset", asd_pkg::RST_BCR, d)
		`CHK("route reset", 3'h4, route)
	endtask
	task automatic t_func();
		logic [2:0] e;
		for (int c = 0; c < 16; c++) begin
			wr(asd_pkg::OFS_BCR, 32'(c) | 32'h10);
			tick(2);
			e = (c == 0 || c > 11) ? 3'h4 : (c == 1) ? 3'h3 :
				(c == 2) ? 3'h0 : (c == 3) ? 3'h1 : 3'h2;
			`CHK("route", e, route)
			if (c >= 4 && c < 12)
				`CHK("monitor", 3'(c - 4), mon_chan)
		end
	endtask
	task automatic t_diff();
		wr(asd_pkg::OFS_BCR, 32'h10);
		wr(asd_pkg::OFS_SCAN, 32'h1);
		gen_a <= 1'b1;
		@(posedge sys_clk);
		gen_a <= 1'b0;
		tick(20);
		gen_a <= 1'b1;
		@(posedge sys_clk);
		gen_a <= 1'b0;
		run('{4'h0, 4'h2, 4'h4, 4'h6}, 1'b1);
	endtask
	task automatic t_soft();
		logic [31:0] d;
		logic [3:0] q[$];
		for (int i = 0; i < 16; i++)
			q.push_back(4'(i));
		slow <= 1'b1;
		wr(asd_pkg::OFS_SCAN, 32'h303);
		wr(asd_pkg::OFS_BCR, 32'h31);
		rd(asd_pkg::OFS_BCR, d);
		`CHK("soft bit busy", 1'b1, d[5])
		run(q, 1'b1);
		rd(asd_pkg::OFS_BCR, d);
		`CHK("soft bit done", 1'b0, d[5])
		slow <= 1'b0;
	endtask
	task automatic t_ext();
		wr(asd_pkg::OFS_BCR, 32'h03);
		wr(asd_pkg::OFS_SCAN, 32'h200);
		ext_sync <= 1'b1;
		tick(10);
		`CHK("rise ignored", 1'b0, busy)
		ext_sync <= 1'b0;
		run('{4'h0, 4'h1}, 1'b0);
	endtask
	task automatic t_single();
		wr(asd_pkg::OFS_BCR, 32'h11);
		wr(asd_pkg::OFS_SCAN, 32'h194);
		gen_b <= 1'b1;
		@(posedge sys_clk);
		gen_b <= 1'b0;
		run('{4'h9}, 1'b1);
	endtask
	task automatic t_out();
		logic [31:0] w[4];
		foreach (w[i]) begin
			w[i] = {11'h7ff, 1'(i), 1'(i >> 1), 3'(i + 5), 16'hc3a0 + 16'(i)};
			wr(asd_pkg::OFS_OUT_PORT, w[i]);
		end
		foreach (w[i]) begin
			tick(4);
			`CHK("head", {1'b1, w[i][20:0]}, {dac_valid, brst_end, grp_end,
				dac_chan, dac_data})
			dac_ready <= 1'b1;
			@(posedge sys_clk);
			dac_ready <= 1'b0;
		end
		tick(4);
		`CHK("drained", 1'b0, dac_valid)
	endtask
	task automatic t_fill();
		logic [31:0] d;
		int n;
		n = 0;
		wr(asd_pkg::OFS_OUT_CTRL, 32'h3);
		while (wr_ready === 1'b1 && n < 34000) begin
			wr(asd_pkg::OFS_OUT_PORT, 32'(n));
			n++;
			#1;
			if (n == asd_pkg::XFER_DEPTH + 3) begin
				tick(4);
				`CHK("flag at thresh", 1'b0, thr_flag)
			end
			if (n == asd_pkg::XFER_DEPTH + 4) begin
				tick(4);
				`CHK("flag over", 1'b1, thr_flag)
				`CHK("rise event", 1, n_ev)
			end
		end
		`CHK("capacity", asd_pkg::OUT_DEPTH + asd_pkg::XFER_DEPTH, n)
		wr(asd_pkg::OFS_OUT_CTRL, 32'h8003);
		tick(4);
		`CHK("cleared", 3'h4, {wr_ready, dac_valid, thr_flag})
		rd(asd_pkg::OFS_OUT_CTRL, d);
		`CHK("clear bit", 32'h3, d)
		`CHK("no fall event", 1, n_ev)
		wr(asd_pkg::OFS_BCR, 32'h51);
		wr(asd_pkg::OFS_OUT_CTRL, 32'h0);
		wr(asd_pkg::OFS_OUT_PORT, 32'h0003_1234);
		tick(6);
		`CHK("fall event", 2, n_ev)
		`CHK("fall flag", 1'b0, thr_flag)
		`CHK("tagged head", 20'hb_1234, {dac_valid, dac_chan, dac_data})
	endtask
	task automatic results();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		srst = 1'b1;
		{reg_wr, reg_rd, gen_a, gen_b, ext_sync, dac_ready, slow} = 7'h0;
		reg_addr = 8'h0;
		reg_wdata = 32'h0;
		repeat (12) @(posedge sys_clk);
		srst <= 1'b0;
		t_reset();
		t_func();
		t_diff();
		t_soft();
		t_ext();
		t_single();
		t_out();
		t_fill();
		results();
	end
endmodule
